//--- include/rol_defines.vh
// Constants for the reset and enable latch block
`ifndef ROL_DEFINES_VH
`define ROL_DEFINES_VH

// Register byte offsets
`define ROL_CTRL_OFS      4'h0
`define ROL_STATUS_OFS    4'h4
`define ROL_LATCH_OFS     4'h8

// Control field positions
`define ROL_CTRL_SRST     0
`define ROL_CTRL_FOFF     1

// Status field positions
`define ROL_ST_READY      16
`define ROL_ST_PINRST     17
`define ROL_ST_CKSEL      18
`define ROL_ST_SRST       19

// Reset values
`define ROL_DRV_RST       8'h00
`define ROL_BIST_RST      8'hFF
`define ROL_CTRL_RST      2'h0

// Cycles counted in the settle state before the run state, kept below 16
`define ROL_SETTLE_CYC    4'h8

`endif

//--- hdl/rol_reset_latches.v
// Device reset handling with driver and self-test enable latches
`timescale 1ns/10ps
`include "rol_defines.vh"

//
// Overview of operation
// - Reset sampled low returns sequencer, driver latch and closed self-test latch home
// - Outputs settle within fewer than sixteen cycles
// - Driver latch transparent while its strobe high
// - Enable bit high drives, low powers down
// - Driver latch holds bus at strobe fall
// - Reset clears driver latch, drivers all off
// - Self-test latch transparent; low bit selects test
// - Self-test latch holds bus at strobe fall
// - Reset with latch closed disables all self-test
// - Both latches follow shared bus independently
// - Clock choice low selects reference capture clock
//

module rol_reset_latches (
    input  wire        clk_sys_i,               // System clock, 125 MHz
    input  wire        reset_n_i,               // Asynchronous reset, active low
    input  wire        chip_reset_low_i,        // Device reset pin, active low
    input  wire        driver_latch_strobe_i,   // Driver latch strobe pin
    input  wire        selftest_latch_strobe_i, // Self-test latch strobe pin
    input  wire [7:0]  shared_enable_bus_i,     // Shared enable bus pins
    input  wire        input_clock_choice_i,    // Input clock choice pin
    input  wire [3:0]  avs_address_i,           // Avalon byte address
    input  wire        avs_read_i,              // Avalon read
    input  wire        avs_write_i,             // Avalon write
    input  wire [31:0] avs_writedata_i,         // Avalon write data
    input  wire [3:0]  avs_byteenable_i,        // Avalon byte enables
    output wire [31:0] avs_readdata_o,          // Avalon read data
    output wire        avs_waitrequest_o,       // Avalon wait request
    output wire [7:0]  serial_line_driver_o,    // Driver enables, high = on
    output wire [3:0]  selftest_run_o,          // Per channel, high = test
    output wire        ref_capture_clk_o,       // High = reference clocks input
    output wire        outputs_ready_o          // Outputs settled
);

    //**********************************************************
    // State encodings
    //**********************************************************
    localparam [2:0] ST_RESET  = 3'h1;          // Device held in reset
    localparam [2:0] ST_SETTLE = 3'h2;          // Counting to settled
    localparam [2:0] ST_RUN    = 3'h4;          // Normal operation

    //**********************************************************
    // Declarations
    //**********************************************************
    reg  [11:0] sync1_r;                        // First synchroniser stage
    reg  [11:0] sync2_r;                        // Second synchroniser stage
    reg  [2:0]  state_r;                        // Sequencer state
    reg  [2:0]  state_nxt;                      // Sequencer next state
    reg  [3:0]  settle_r;                       // Settle counter
    reg  [3:0]  settle_nxt;                     // Settle counter next
    reg  [7:0]  drv_latch_r;                    // Driver enable latch
    reg  [7:0]  bist_latch_r;                   // Self-test enable latch
    reg  [7:0]  drv_out_r;                      // Registered driver enables
    reg  [3:0]  bist_out_r;                     // Registered test selects
    reg         cksel_r;                        // Registered clock choice
    reg         ready_r;                        // Registered settled flag
    reg  [1:0]  ctrl_r;                         // Control register
    reg  [31:0] rdata_r;                        // Read data register
    reg  [31:0] rdata_nxt;                      // Read data next
    reg         wait_r;                         // Wait request register
    wire        pin_rst_n;                      // Synced reset pin
    wire        drv_stb;                        // Synced driver strobe
    wire        bist_stb;                       // Synced self-test strobe
    wire [7:0]  bus_s;                          // Synced enable bus
    wire        ck_choice;                      // Synced clock choice
    wire        dev_rst;                        // Pin or soft reset
    wire        bus_req;                        // Bus request present
    wire        bus_done;                       // Access completes now
    wire        ctrl_wr;                        // Control write strobe
    wire [3:0]  bist_ch;                        // Test select per channel

    //**********************************************************
    // Pin synchronisers
    //**********************************************************
    // Every pin is asynchronous; two stages before any use.
    // Bus and strobes share the same delay, so the value seen
    // with the strobe still high is the one held at its fall.
    // Reset shows strobes closed and the reset pin active, so no
    // latch opens on a stale value before the real pins are seen.
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_r <= 12'h8FF;
            sync2_r <= 12'h8FF;
        end else begin
            sync1_r <= {input_clock_choice_i, chip_reset_low_i,
                        selftest_latch_strobe_i, driver_latch_strobe_i,
                        shared_enable_bus_i};
            sync2_r <= sync1_r;
        end
    end

    assign bus_s     = sync2_r[7:0];
    assign drv_stb   = sync2_r[8];
    assign bist_stb  = sync2_r[9];
    assign pin_rst_n = sync2_r[10];
    assign ck_choice = sync2_r[11];

    // Soft reset from software acts like the pin
    assign dev_rst = ~pin_rst_n | ctrl_r[`ROL_CTRL_SRST];

    //**********************************************************
    // Reset sequencer
    //**********************************************************
    // Holds home while reset is seen, then counts a fixed
    // number of cycles before outputs are declared settled.
    always @* begin
        state_nxt  = state_r;
        settle_nxt = settle_r;
        if (dev_rst) begin
            // Reset seen at this edge: go home
            state_nxt  = ST_RESET;
            settle_nxt = 4'h0;
        end else begin
            case (state_r)
                ST_RESET: begin
                    state_nxt  = ST_SETTLE;
                    settle_nxt = 4'h0;
                end
                ST_SETTLE: begin
                    // Settle time well below sixteen cycles
                    if (settle_r == `ROL_SETTLE_CYC - 4'h1) begin
                        state_nxt = ST_RUN;
                    end else begin
                        settle_nxt = settle_r + 4'h1;
                    end
                end
                ST_RUN: begin
                    state_nxt = ST_RUN;
                end
                default: begin
                    // Illegal code recovers through reset
                    state_nxt  = ST_RESET;
                    settle_nxt = 4'h0;
                end
            endcase
        end
    end

    // Sequencer registers
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_r  <= ST_RESET;
            settle_r <= 4'h0;
        end else begin
            state_r  <= state_nxt;
            settle_r <= settle_nxt;
        end
    end

    //**********************************************************
    // Driver enable latch
    //**********************************************************
    // Reset wins over the strobe: drivers must stay off.
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drv_latch_r <= `ROL_DRV_RST;
        end else if (dev_rst) begin
            drv_latch_r <= `ROL_DRV_RST;
        end else if (drv_stb) begin
            // Open: follow the bus
            drv_latch_r <= bus_s;
        end else begin
            // Closed: hold the value from the strobe fall
            drv_latch_r <= drv_latch_r;
        end
    end

    //**********************************************************
    // Self-test enable latch
    //**********************************************************
    // Reset only clears it when closed; an open latch keeps
    // following the bus even through a reset.
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bist_latch_r <= `ROL_BIST_RST;
        end else if (bist_stb) begin
            // Open: follow the bus
            bist_latch_r <= bus_s;
        end else if (dev_rst) begin
            // All ones means normal data everywhere
            bist_latch_r <= `ROL_BIST_RST;
        end else begin
            // Closed: hold the value from the strobe fall
            bist_latch_r <= bist_latch_r;
        end
    end

    //**********************************************************
    // Channel mapping
    //**********************************************************
    // Even bit of each pair selects the channel generator;
    // low means run the test sequence.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
            assign bist_ch[gi] = ~bist_latch_r[2 * gi];
        end
    endgenerate

    //**********************************************************
    // Registered outputs
    //**********************************************************
    // Drivers stay off until settled so nothing random leaves
    // the pins; costs one cycle of latency on each change.
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drv_out_r  <= `ROL_DRV_RST;
            bist_out_r <= 4'h0;
            cksel_r    <= 1'b0;
            ready_r    <= 1'b0;
        end else begin
            if ((state_r == ST_RUN) && !ctrl_r[`ROL_CTRL_FOFF]) begin
                // Bit high drives its line, low powers down
                drv_out_r <= drv_latch_r;
            end else begin
                drv_out_r <= `ROL_DRV_RST;
            end
            bist_out_r <= bist_ch;
            // Choice low: reference clock captures input data
            cksel_r    <= ~ck_choice;
            ready_r    <= (state_r == ST_RUN);
        end
    end

    assign serial_line_driver_o = drv_out_r;
    assign selftest_run_o       = bist_out_r;
    assign ref_capture_clk_o    = cksel_r;
    assign outputs_ready_o      = ready_r;

    //**********************************************************
    // Avalon slave
    //**********************************************************
    // Fixed one wait cycle: the request is registered first,
    // then waitrequest drops for exactly one cycle.
    assign bus_req  = avs_read_i | avs_write_i;
    assign bus_done = bus_req & ~wait_r;
    assign ctrl_wr  = avs_write_i & bus_done &
                      (avs_address_i == `ROL_CTRL_OFS) &
                      avs_byteenable_i[0];

    // Wait request generator
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_r <= 1'b1;
        end else begin
            wait_r <= ~(bus_req & wait_r);
        end
    end

    // Control register, written in byte lane zero only
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_r <= `ROL_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_r <= avs_writedata_i[1:0];
        end
    end

    // Read data selection; unmapped addresses read zero
    always @* begin
        rdata_nxt = 32'h0;
        case (avs_address_i)
            `ROL_CTRL_OFS: begin
                rdata_nxt[1:0] = ctrl_r;
            end
            `ROL_STATUS_OFS: begin
                rdata_nxt[7:0]            = drv_out_r;
                rdata_nxt[11:8]           = bist_out_r;
                rdata_nxt[`ROL_ST_READY]  = ready_r;
                rdata_nxt[`ROL_ST_PINRST] = ~pin_rst_n;
                rdata_nxt[`ROL_ST_CKSEL]  = cksel_r;
                rdata_nxt[`ROL_ST_SRST]   = ctrl_r[`ROL_CTRL_SRST];
            end
            `ROL_LATCH_OFS: begin
                rdata_nxt[7:0]  = drv_latch_r;
                rdata_nxt[15:8] = bist_latch_r;
            end
            default: begin
                rdata_nxt = 32'h0;
            end
        endcase
    end

    // Read data captured in the wait cycle, stands at done
    always @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_r <= 32'h0;
        end else if (avs_read_i & wait_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata_o    = rdata_r;
    assign avs_waitrequest_o = wait_r;

endmodule // rol_reset_latches

//--- sim/rol_host_model.sv
// Board host model driving reset, latch strobes, enable bus and clock choice
`timescale 1ns/10ps
module rol_host_model (
    input  wire         clk_sys_i, // System clock
    input  wire         reset_n_i, // Power-up reset, active low
    input  wire  [11:0] req_i,     // Wanted levels: reset, two strobes, bus, choice
    output logic [11:0] pins_o     // Pins as driven: {reset, driver, self-test, bus, choice}
);
    // Pins move just after an edge and then stand still, as a static host does
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i)
            pins_o <= 12'h1FE;
        else
            pins_o <= req_i;
    end
endmodule // rol_host_model

//--- sim/rol_reset_latches_assertions.sv
// Port checker for the reset and enable latch block
`timescale 1ns/10ps
module rol_reset_latches_assertions (
    input wire       clk_sys_i,
    input wire       reset_n_i,
    input wire       chip_reset_low_i,
    input wire       driver_latch_strobe_i,
    input wire       selftest_latch_strobe_i,
    input wire [7:0] shared_enable_bus_i,
    input wire       input_clock_choice_i,
    input wire [7:0] serial_line_driver_o,
    input wire [3:0] selftest_run_o,
    input wire       ref_capture_clk_o,
    input wire       outputs_ready_o
);
    // ******************************
    // Windows cover two sync stages, the latch and the output register
    // ******************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_rst_low; !chip_reset_low_i [*6]; endsequence
    sequence s_drv_open; (driver_latch_strobe_i && $stable(shared_enable_bus_i) && outputs_ready_o) [*7]; endsequence
    sequence s_st_open; (selftest_latch_strobe_i && $stable(shared_enable_bus_i)) [*7]; endsequence
    // Force-off and soft reset may zero outputs, so driver moves to or from zero pass, and self-test moves to zero
    a_reset_home: assert property (s_rst_low |-> !outputs_ready_o) else $error("ready in reset");
    a_settle_time: assert property ($rose(chip_reset_low_i) |-> ##[1:15] outputs_ready_o) else $error("slow");
    a_drv_cleared: assert property (s_rst_low |-> serial_line_driver_o == 8'h00) else $error("drivers on");
    a_drv_follow: assert property (s_drv_open |-> serial_line_driver_o inside {shared_enable_bus_i, 8'h00})
        else $error("driver latch shut");
    a_drv_hold: assert property ((!driver_latch_strobe_i && outputs_ready_o) [*6] |-> $stable(serial_line_driver_o)
        || serial_line_driver_o == 8'h00 || $past(serial_line_driver_o) == 8'h00) else $error("driver latch moved");
    a_st_follow: assert property (s_st_open |-> selftest_run_o == ~{shared_enable_bus_i[6],
        shared_enable_bus_i[4], shared_enable_bus_i[2], shared_enable_bus_i[0]}) else $error("test latch shut");
    a_st_hold: assert property ((!selftest_latch_strobe_i && chip_reset_low_i) [*6] |-> $stable(selftest_run_o)
        || selftest_run_o == 4'h0) else $error("test latch moved");
    a_st_cleared: assert property ((!chip_reset_low_i && !selftest_latch_strobe_i) [*6] |-> selftest_run_o == 4'h0)
        else $error("test left on");
    a_clock_choice: assert property ($stable(input_clock_choice_i) [*7] |-> ref_capture_clk_o == !input_clock_choice_i)
        else $error("clock choice");
endmodule // rol_reset_latches_assertions
bind rol_reset_latches rol_reset_latches_assertions rol_reset_latches_assertions_i (.clk_sys_i, .reset_n_i,
    .chip_reset_low_i, .driver_latch_strobe_i, .selftest_latch_strobe_i, .shared_enable_bus_i,
    .input_clock_choice_i, .serial_line_driver_o, .selftest_run_o, .ref_capture_clk_o, .outputs_ready_o);

//--- sim/rol_reset_latches_tb.sv
// Self-checking bench for the reset and enable latch block
`timescale 1ns/10ps
module rol_reset_latches_tb;
    logic        clk_sys_i = 1'h0;           // 125 MHz clock
    logic        reset_n_i = 1'h0;           // Bench reset, active low
    logic [11:0] req = 12'h000;              // Host levels wanted
    logic [3:0]  adr = 4'h0, be = 4'hF;      // Bus address, byte enables
    logic        rd = 1'h0, wr = 1'h0;       // Bus strobes
    logic [31:0] wd = 32'h0, q, seed = 32'h11; // Write data, read word, xorshift state
    logic [7:0]  drv_m = 8'h00, st_m = 8'hFF; // Model latches
    logic        frc = 1'h0, srs = 1'h0;     // Model force-off and soft reset
    int          miscompares = 0, num_checks = 0, cyc = 0;
    wire  [11:0] pins;                       // Host pins
    wire  [31:0] rdata;                      // Read data
    wire  [7:0]  drv;                        // Driver enables
    wire  [3:0]  run;                        // Self-test per channel
    wire         wt, refc, rdy;              // Wait, capture clock, ready
    rol_host_model rol_host_model_i (.clk_sys_i, .reset_n_i, .req_i(req), .pins_o(pins));
    rol_reset_latches rol_reset_latches_i (.clk_sys_i, .reset_n_i, .chip_reset_low_i(pins[11]),
        .driver_latch_strobe_i(pins[10]), .selftest_latch_strobe_i(pins[9]), .shared_enable_bus_i(pins[8:1]),
        .input_clock_choice_i(pins[0]), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wd), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
        .serial_line_driver_o(drv), .selftest_run_o(run), .ref_capture_clk_o(refc), .outputs_ready_o(rdy));
    always #4 clk_sys_i = ~clk_sys_i;
    // A hang ends the run well past the expected length
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            miscompares++;
            finish_test;
        end
    end
    function automatic [31:0] xs(input [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One access, held until waitrequest is seen low
    task bus(input w, input [3:0] a, input [31:0] d, input [3:0] e);
        @(posedge clk_sys_i);
        {rd, wr, adr, wd, be} <= {!w, w, a, d, e};
        do @(posedge clk_sys_i); while (wt !== 1'h0);
        q = rdata;
        {rd, wr} <= 2'h0;
    endtask
    // Move host pins, update the model, then allow the sync and settle time
    task pins_set(input r, o, s, input [7:0] b, input c);
        @(posedge clk_sys_i);
        req <= {r, o, s, b, c};
        if (o && r) drv_m = b;
        if (s) st_m = b;
        if (!r) drv_m = 8'h00;
        if (!r && !s) st_m = 8'hFF;
        repeat (20) @(posedge clk_sys_i);
    endtask
    task cmp_all;
        logic [3:0] es;
        logic [7:0] ed;
        es = ~{st_m[6], st_m[4], st_m[2], st_m[0]};
        ed = frc ? 8'h00 : drv_m;
        repeat (3) @(posedge clk_sys_i);
        chk(drv, ed);
        chk(run, es);
        chk(rdy, req[11] & !srs);
        chk(refc, !req[0]);
        bus(1'h0, 4'h4, 32'h0, 4'hF);
        chk(q, {12'h0, srs, !req[0], !req[11], req[11] & !srs, 4'h0, es, ed});
        bus(1'h0, 4'h8, 32'h0, 4'hF);
        chk(q, {16'h0, st_m, drv_m});
    endtask
    task finish_test;
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys_i);
        reset_n_i <= 1'h1;
        pins_set(1'h0, 1'h0, 1'h0, 8'hFF, 1'h0);
        cmp_all;
        pins_set(1'h1, 1'h0, 1'h0, 8'hFF, 1'h0);
        cmp_all;
        $display("test power-up reset done");
        // Bus stays steady across each strobe fall; the other latch must not move
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            pins_set(1'h1, 1'h1, 1'h0, seed[7:0], i[0]);
            cmp_all;
            pins_set(1'h1, 1'h0, 1'h0, seed[7:0], i[0]);
            pins_set(1'h1, 1'h0, 1'h1, seed[15:8], i[0]);
            cmp_all;
            pins_set(1'h1, 1'h0, 1'h0, seed[15:8], i[0]);
            pins_set(1'h1, 1'h0, 1'h0, seed[23:16], i[0]);
            cmp_all;
        end
        $display("test latch follow and hold done");
        bus(1'h1, 4'h0, 32'h2, 4'hF);
        frc = 1'h1;
        cmp_all;
        bus(1'h1, 4'h0, 32'h0, 4'h0);
        cmp_all;
        bus(1'h1, 4'h0, 32'h0, 4'hF);
        frc = 1'h0;
        bus(1'h1, 4'hC, 32'hFFFF_FFFF, 4'hF);
        bus(1'h0, 4'hC, 32'h0, 4'hF);
        chk(q, 32'h0);
        cmp_all;
        // Soft reset acts like the pin: closed latches clear, ready drops
        bus(1'h1, 4'h0, 32'h1, 4'hF);
        srs = 1'h1;
        drv_m = 8'h00;
        st_m = 8'hFF;
        repeat (20) @(posedge clk_sys_i);
        cmp_all;
        bus(1'h1, 4'h0, 32'h0, 4'hF);
        srs = 1'h0;
        repeat (20) @(posedge clk_sys_i);
        cmp_all;
        $display("test register access done");
        pins_set(1'h0, 1'h0, 1'h1, 8'h5A, 1'h0);
        pins_set(1'h0, 1'h0, 1'h0, 8'h5A, 1'h0);
        cmp_all;
        pins_set(1'h1, 1'h0, 1'h0, 8'h5A, 1'h0);
        cmp_all;
        $display("test device reset done");
        finish_test;
    end
endmodule // rol_reset_latches_tb
